// ===== core/tick_select.v
// prescaler and clock source selection producing the timer tick enable
`include "timer_defines.vh"
module tick_select
(
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [2:0] clock_source_sel,
    input  wire       ext_clk_in,
    output reg        timer_tick_enable
);
    reg [`PRESCALE_WIDTH-1:0] pre_q;
    reg                       ext_q;
    wire ext_rise = ext_clk_in & ~ext_q;
    wire ext_fall = ~ext_clk_in & ext_q;

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_q <= {`PRESCALE_WIDTH{1'b0}};
            ext_q <= 1'b0;
        end
        else
        begin
            pre_q <= pre_q + 1'b1;
            ext_q <= ext_clk_in;
        end
    end

    // tick is combinational so it lines up with the counter enable
    always @*
    begin
        case (clock_source_sel)
            `CS_STOP:     timer_tick_enable = 1'b0;
            `CS_DIV1:     timer_tick_enable = 1'b1;
            `CS_DIV8:     timer_tick_enable = (pre_q[2:0] == 3'h7);
            `CS_DIV64:    timer_tick_enable = (pre_q[5:0] == 6'h3F);
            `CS_DIV256:   timer_tick_enable = (pre_q[7:0] == 8'hFF);
            `CS_DIV1024:  timer_tick_enable = (pre_q == 10'h3FF);
            `CS_EXT_FALL: timer_tick_enable = ext_fall;
            `CS_EXT_RISE: timer_tick_enable = ext_rise;
            default:      timer_tick_enable = 1'b0;
        endcase
    end
endmodule // tick_select

// ===== core/timer_waveform.v
// 8-bit timer with two compare channels behind an avalon-mm slave
// Function
// - timer tick is a clock enable on the single system clock
// - nonzero channel a mode overrides pin; driven only when direction selects output
// - non-pwm channel a: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm channel a: 01 toggles if mode high bit; 10/11 non-inverting/inverting
// - phase correct channel a: 10 clear up, set down; 11 reverse; 01 toggle if high
// - pwm channel a compare equal top with high bit: match ignored, action at top
// - nonzero channel b mode overrides pin; driven only when direction selects output
// - non-pwm channel b: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm channel b: 01 reserved; 10 clear/set top; 11 set/clear top
// - phase correct channel b: 01 reserved; 10 clear up, set down; 11 reverse
// - pwm channel b compare equal top with high bit: match ignored, action at top
// - control a bits 3 and 2 always read zero
// - mode from two control a bits plus one control b bit
// - top is 0xFF in modes 0,1,3; compare a in 2,5,7
// - compare writes immediate in non-pwm, buffered to top in pwm
// - overflow flag at max in 0,2,3; bottom in 1,5; top in 7
// - fast pwm counts bottom to top then restarts at bottom
// - phase correct counts up then down, reversing at top and at bottom with no hold tick
// - clock select: stop, divide 1/8/64/256/1024, external fall or rise
`include "timer_defines.vh"
module timer_waveform
(
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [2:0] avs_address,
    input  wire       avs_read,
    input  wire       avs_write,
    input  wire [7:0] avs_writedata,
    output reg  [7:0] avs_readdata,
    output wire       avs_waitrequest,
    input  wire       ext_clk_in,
    input  wire       chan_a_dir_out,
    input  wire       chan_b_dir_out,
    output wire       chan_a_wave_out,
    output wire       chan_a_wave_oe_b,
    output wire       chan_b_wave_out,
    output wire       chan_b_wave_oe_b
);
    reg  [7:0] timer_waveform_control_a_q;
    reg  [3:0] timer_clock_control_b_q;
    reg  [7:0] counter_value_q;
    reg        count_down_q;
    reg        overflow_flag_q;
    reg        chan_a_match_flag_q;
    reg        chan_b_match_flag_q;
    reg        block_q;
    reg        rd_done_q;
    reg  [7:0] count_d;
    reg        down_d;
    reg        ovf_evt;

    wire       timer_tick_enable;
    wire [7:0] cmp_a_buf;
    wire [7:0] cmp_a_act;
    wire [7:0] cmp_b_buf;
    wire [7:0] cmp_b_act;
    wire       wave_a;
    wire       wave_b;
    wire       match_a;
    wire       match_b;

    wire [1:0] chan_a_output_mode   = timer_waveform_control_a_q[7:6];
    wire [1:0] chan_b_output_mode   = timer_waveform_control_a_q[5:4];
    wire [1:0] generation_mode_low  = timer_waveform_control_a_q[1:0];
    wire       generation_mode_high = timer_clock_control_b_q[`BIT_WGM_HI];
    wire [2:0] clock_source_sel     = timer_clock_control_b_q[2:0];
    wire [2:0] generation_mode_sel  = {generation_mode_high, generation_mode_low};

    wire pwm_mode  = generation_mode_low[0];
    wire fast_mode = (generation_mode_low == 2'h3);
    wire pc_mode   = pwm_mode && !fast_mode;
    wire ctc_mode  = (generation_mode_sel == `MODE_CTC);
    wire var_top   = (generation_mode_sel == `MODE_CTC) || (generation_mode_sel == `MODE_PC_VAR) ||
                     (generation_mode_sel == `MODE_FAST_VAR);
    wire [7:0] top_value = var_top ? cmp_a_act : `VAL_MAX;
    wire at_top    = (counter_value_q == top_value);
    wire at_bottom = (counter_value_q == `VAL_BOTTOM);

    wire wr_en = avs_write;
    wire wr_cnt   = wr_en && (avs_address == `ADDR_COUNT);
    wire wr_cmp_a = wr_en && (avs_address == `ADDR_CMP_A);
    wire wr_cmp_b = wr_en && (avs_address == `ADDR_CMP_B);
    wire wr_flags = wr_en && (avs_address == `ADDR_FLAGS);

    // writes complete at once; a read takes one wait cycle so data comes from a flop
    assign avs_waitrequest = avs_read && !rd_done_q;

    tick_select u_tick
    (
        .clk_sys           (clk_sys),
        .rst_b             (rst_b),
        .clock_source_sel  (clock_source_sel),
        .ext_clk_in        (ext_clk_in),
        .timer_tick_enable (timer_tick_enable)
    );

    wave_channel #(.TOGGLE_IN_PWM(1)) u_chan_a
    (
        .clk_sys       (clk_sys),
        .rst_b         (rst_b),
        .tick          (timer_tick_enable),
        .pwm_mode      (pwm_mode),
        .fast_mode     (fast_mode),
        .gen_high      (generation_mode_high),
        .count_down    (count_down_q),
        .at_top        (at_top),
        .at_bottom     (at_bottom),
        .counter_value (counter_value_q),
        .top_value     (top_value),
        .output_mode   (chan_a_output_mode),
        .cmp_wr        (wr_cmp_a),
        .cmp_wdata     (avs_writedata),
        .block_match   (block_q),
        .cmp_buf_q     (cmp_a_buf),
        .cmp_act_q     (cmp_a_act),
        .wave_q        (wave_a),
        .match         (match_a)
    );

    wave_channel #(.TOGGLE_IN_PWM(0)) u_chan_b
    (
        .clk_sys       (clk_sys),
        .rst_b         (rst_b),
        .tick          (timer_tick_enable),
        .pwm_mode      (pwm_mode),
        .fast_mode     (fast_mode),
        .gen_high      (generation_mode_high),
        .count_down    (count_down_q),
        .at_top        (at_top),
        .at_bottom     (at_bottom),
        .counter_value (counter_value_q),
        .top_value     (top_value),
        .output_mode   (chan_b_output_mode),
        .cmp_wr        (wr_cmp_b),
        .cmp_wdata     (avs_writedata),
        .block_match   (block_q),
        .cmp_buf_q     (cmp_b_buf),
        .cmp_act_q     (cmp_b_act),
        .wave_q        (wave_b),
        .match         (match_b)
    );

    // pin override: the enable is low while the waveform drives the pin
    assign chan_a_wave_out  = wave_a;
    assign chan_a_wave_oe_b = ~((chan_a_output_mode != `COM_OFF) && chan_a_dir_out);
    assign chan_b_wave_out  = wave_b;
    assign chan_b_wave_oe_b = ~((chan_b_output_mode != `COM_OFF) && chan_b_dir_out);

    // next counter value and overflow event for one tick
    always @*
    begin
        count_d = counter_value_q;
        down_d  = count_down_q;
        ovf_evt = 1'b0;
        if (pc_mode)
        begin
            if (!count_down_q)
            begin
                if (at_top)
                begin
                    down_d  = 1'b1;
                    count_d = counter_value_q - 8'h01;
                end
                else
                    count_d = counter_value_q + 8'h01;
            end
            else if (at_bottom)
            begin
                down_d  = 1'b0;
                count_d = counter_value_q + 8'h01;
                ovf_evt = 1'b1;
            end
            else
                count_d = counter_value_q - 8'h01;
        end
        else
        begin
            down_d = 1'b0;
            if ((fast_mode || ctc_mode) && at_top)
                count_d = `VAL_BOTTOM;
            else
                count_d = counter_value_q + 8'h01;
            if (generation_mode_sel == `MODE_FAST_VAR)
                ovf_evt = at_top;
            else
                ovf_evt = (counter_value_q == `VAL_MAX);
        end
    end

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer_waveform_control_a_q <= 8'h00;
            timer_clock_control_b_q    <= 4'h0;
            counter_value_q            <= `VAL_BOTTOM;
            count_down_q               <= 1'b0;
            overflow_flag_q            <= 1'b0;
            chan_a_match_flag_q        <= 1'b0;
            chan_b_match_flag_q        <= 1'b0;
            block_q                    <= 1'b0;
            rd_done_q                  <= 1'b0;
            avs_readdata               <= 8'h00;
        end
        else
        begin
            if (wr_en && avs_address == `ADDR_CTRL_A)
                timer_waveform_control_a_q <= avs_writedata & `CTRL_A_WMASK;
            if (wr_en && avs_address == `ADDR_CTRL_B)
                timer_clock_control_b_q <= avs_writedata[3:0];
            // a counter write suppresses the compare match on the following tick
            if (wr_cnt)
            begin
                counter_value_q <= avs_writedata;
                block_q         <= 1'b1;
            end
            else if (timer_tick_enable)
            begin
                counter_value_q <= count_d;
                count_down_q    <= down_d;
                block_q         <= 1'b0;
            end
            // set wins over a software clear in the same cycle
            overflow_flag_q <= (timer_tick_enable && ovf_evt) ||
                               (overflow_flag_q && !(wr_flags && avs_writedata[`BIT_FLAG_OVF]));
            chan_a_match_flag_q <= match_a ||
                                   (chan_a_match_flag_q && !(wr_flags && avs_writedata[`BIT_FLAG_MA]));
            chan_b_match_flag_q <= match_b ||
                                   (chan_b_match_flag_q && !(wr_flags && avs_writedata[`BIT_FLAG_MB]));
            rd_done_q <= avs_read && !rd_done_q;
            if (avs_read && !rd_done_q)
            begin
                case (avs_address)
                    `ADDR_CTRL_A: avs_readdata <= timer_waveform_control_a_q & `CTRL_A_WMASK;
                    `ADDR_CTRL_B: avs_readdata <= {4'h0, timer_clock_control_b_q};
                    `ADDR_COUNT:  avs_readdata <= counter_value_q;
                    `ADDR_CMP_A:  avs_readdata <= cmp_a_buf;
                    `ADDR_CMP_B:  avs_readdata <= cmp_b_buf;
                    `ADDR_FLAGS:  avs_readdata <= {5'h00, chan_b_match_flag_q, chan_a_match_flag_q, overflow_flag_q};
                    default:      avs_readdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // timer_waveform

// ===== core/wave_channel.v
// one compare output channel: buffered compare value and waveform bit
`include "timer_defines.vh"
module wave_channel
#(
    parameter TOGGLE_IN_PWM = 1
)
(
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       tick,
    input  wire       pwm_mode,
    input  wire       fast_mode,
    input  wire       gen_high,
    input  wire       count_down,
    input  wire       at_top,
    input  wire       at_bottom,
    input  wire [7:0] counter_value,
    input  wire [7:0] top_value,
    input  wire [1:0] output_mode,
    input  wire       cmp_wr,
    input  wire [7:0] cmp_wdata,
    input  wire       block_match,
    output reg  [7:0] cmp_buf_q,
    output reg  [7:0] cmp_act_q,
    output reg        wave_q,
    output wire       match
);
    wire equal      = (counter_value == cmp_act_q) && !block_match;
    wire top_case   = pwm_mode && output_mode[1] && (cmp_act_q == top_value);
    assign match    = tick && equal;
    wire pwm_toggle = (TOGGLE_IN_PWM != 0) && gen_high;
    reg  wave_d;

    always @*
    begin
        wave_d = wave_q;
        if (!pwm_mode)
        begin
            if (match)
            begin
                case (output_mode)
                    `COM_TOGGLE: wave_d = ~wave_q;
                    `COM_CLEAR:  wave_d = 1'b0;
                    `COM_SET:    wave_d = 1'b1;
                    default:     wave_d = wave_q;
                endcase
            end
        end
        else if (tick)
        begin
            if (fast_mode)
            begin
                if (top_case && at_top)
                    wave_d = (output_mode == `COM_SET) ? 1'b0 : 1'b1;
                else if (equal && !top_case)
                begin
                    if (output_mode == `COM_TOGGLE && pwm_toggle)
                        wave_d = ~wave_q;
                    else if (output_mode == `COM_CLEAR)
                        wave_d = 1'b0;
                    else if (output_mode == `COM_SET)
                        wave_d = 1'b1;
                end
                else if (at_top && output_mode[1])
                    wave_d = (output_mode == `COM_CLEAR);
            end
            else
            begin
                if (top_case && at_top)
                    wave_d = (output_mode == `COM_CLEAR);
                else if (equal && !top_case)
                begin
                    if (output_mode == `COM_TOGGLE && pwm_toggle)
                        wave_d = ~wave_q;
                    else if (output_mode[1])
                        wave_d = (output_mode == `COM_CLEAR) ? count_down : ~count_down;
                end
            end
        end
    end

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmp_buf_q <= `VAL_BOTTOM;
            cmp_act_q <= `VAL_BOTTOM;
            wave_q    <= 1'b0;
        end
        else
        begin
            wave_q <= wave_d;
            if (cmp_wr)
                cmp_buf_q <= cmp_wdata;
            if (!pwm_mode && cmp_wr)
                cmp_act_q <= cmp_wdata;
            else if (pwm_mode && tick && at_top)
                cmp_act_q <= cmp_buf_q;
            else if (!pwm_mode)
                cmp_act_q <= cmp_buf_q;
        end
    end
endmodule // wave_channel

// ===== dv/timer_waveform_properties.sv
// port level checker for the waveform timer
`include "timer_defines.vh"
module timer_waveform_properties
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [2:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [7:0] avs_readdata,
    input  wire logic       avs_waitrequest,
    input  wire logic       chan_a_dir_out,
    input  wire logic       chan_b_dir_out,
    input  wire logic       chan_a_wave_out,
    input  wire logic       chan_a_wave_oe_b,
    input  wire logic       chan_b_wave_out,
    input  wire logic       chan_b_wave_oe_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire rd_done = avs_read && !avs_waitrequest;
    dir_gate_a_a: assert property (!chan_a_dir_out |-> chan_a_wave_oe_b)
        else $error("channel a driven while direction is input");
    dir_gate_b_a: assert property (!chan_b_dir_out |-> chan_b_wave_oe_b)
        else $error("channel b driven while direction is input");
    oe_cause_a_a: assert property ($changed(chan_a_wave_oe_b) |->
        $changed(chan_a_dir_out) || $past(avs_write && avs_address == `ADDR_CTRL_A))
        else $error("channel a enable changed without cause");
    oe_cause_b_a: assert property ($changed(chan_b_wave_oe_b) |->
        $changed(chan_b_dir_out) || $past(avs_write && avs_address == `ADDR_CTRL_A))
        else $error("channel b enable changed without cause");
    reset_idle_a: assert property ($rose(rst_b) |-> chan_a_wave_oe_b && chan_b_wave_oe_b
        && !chan_a_wave_out && !chan_b_wave_out)
        else $error("outputs not idle after reset");
    rsv_zero_a: assert property (rd_done && avs_address == `ADDR_CTRL_A |-> avs_readdata[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");
    unmapped_zero_a: assert property (rd_done && avs_address > `ADDR_FLAGS |-> avs_readdata == 8'h00)
        else $error("unmapped read not zero");
    read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer timing wrong");
    write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    read_cov_c: cover property (rd_done);
    drive_a_c: cover property (!chan_a_wave_oe_b && chan_a_wave_out);
    drive_b_c: cover property (!chan_b_wave_oe_b && $rose(chan_b_wave_out));
endmodule // timer_waveform_properties
bind timer_waveform timer_waveform_properties timer_waveform_properties_i (.*);

// ===== dv/timer_waveform_tb_top.sv
// register level testbench of the waveform timer
`include "timer_defines.vh"
module timer_waveform_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys, rst_b, avs_read, avs_write, ext_clk_in, dir_a, dir_b;
    logic [2:0] avs_address;
    logic [7:0] avs_writedata, d;
    wire  [7:0] avs_readdata;
    wire        avs_waitrequest, wa, oa, wb, ob, pin_a, pin_b;
    integer     fail_count = 0;
    integer     n_tests = 0;
    integer     i;
    logic [7:0] tbl_mode [0:3] = '{8'h70, 8'hA0, 8'hD0, 8'h70};
    logic [1:0] tbl_exp  [0:3] = '{2'b11, 2'b00, 2'b11, 2'b01};
    timer_waveform timer_waveform_i (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_clk_in(ext_clk_in),
        .chan_a_dir_out(dir_a), .chan_b_dir_out(dir_b), .chan_a_wave_out(wa), .chan_a_wave_oe_b(oa),
        .chan_b_wave_out(wb), .chan_b_wave_oe_b(ob));
    wave_pin_load wave_pin_load_i (.clk_sys(clk_sys), .wave_a(wa), .oe_a_b(oa), .wave_b(wb),
        .oe_b_b(ob), .pin_a(pin_a), .pin_b(pin_b));
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        int k = 0;
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        // look at waitrequest once it has settled, then pass the edge that samples it low
        @(negedge clk_sys);
        while (avs_waitrequest !== 1'b0 && k < 50)
        begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 50)
        begin
            fail_count++;
            $display("[FAIL] %0t write not answered", $time);
        end
        @(posedge clk_sys);
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        int k = 0;
        avs_address <= a;
        avs_read <= 1'b1;
        @(negedge clk_sys);
        while (avs_waitrequest !== 1'b0 && k < 50)
        begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 50)
        begin
            fail_count++;
            $display("[FAIL] %0t read not answered", $time);
        end
        @(posedge clk_sys);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    // n external rising edges, one per count, so exactly n counts whatever the detector latency
    task automatic tick(input int n);
        repeat (n)
        begin
            ext_clk_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            ext_clk_in <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    task automatic done_test(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, fail_count);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end
    initial
    begin
        {rst_b, avs_read, avs_write, ext_clk_in, dir_a, dir_b} = 6'h00;
        avs_address = 3'h0;
        avs_writedata = 8'h00;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        for (i = 0; i < 6; i++)
        begin
            rd(i[2:0], d);
            chk8(d, 8'h00);
        end
        chk8({4'h0, oa, ob, wa, wb}, 8'h0C);
        wr(3'h6, 8'hA5);
        rd(3'h6, d);
        chk8(d, 8'h00);
        wr(`ADDR_CTRL_A, 8'hFF);
        rd(`ADDR_CTRL_A, d);
        chk8(d, 8'hF3);
        done_test("reset_and_map");
        for (i = 0; i < 4; i++)
        begin
            wr(`ADDR_CTRL_A, {i[1:0], i[1:0], 4'h0});
            dir_a <= 1'b0;
            dir_b <= 1'b0;
            @(posedge clk_sys);
            chk8({6'h00, oa, ob}, 8'h03);
            dir_a <= 1'b1;
            dir_b <= 1'b1;
            @(posedge clk_sys);
            chk8({6'h00, oa, ob}, (i == 0) ? 8'h03 : 8'h00);
            chk8({6'h00, pin_a, pin_b}, (i == 0) ? 8'h03 : 8'h00);
        end
        done_test("pin_enable");
        wr(`ADDR_CTRL_B, {5'h00, `CS_EXT_RISE});
        wr(`ADDR_CMP_A, 8'h03);
        wr(`ADDR_CMP_B, 8'h03);
        for (i = 0; i < 4; i++)
        begin
            wr(`ADDR_CTRL_A, tbl_mode[i]);
            wr(`ADDR_COUNT, 8'h01);
            tick(4);
            chk1(wa, tbl_exp[i][1]);
            chk1(wb, tbl_exp[i][0]);
        end
        rd(`ADDR_FLAGS, d);
        chk8(d & 8'h06, 8'h06);
        wr(`ADDR_FLAGS, 8'h07);
        wr(`ADDR_COUNT, 8'hFE);
        tick(2);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h00);
        rd(`ADDR_FLAGS, d);
        chk8(d, 8'h01);
        done_test("normal");
        wr(`ADDR_CMP_A, 8'h05);
        wr(`ADDR_CTRL_A, 8'h72);
        wr(`ADDR_COUNT, 8'h00);
        tick(5);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h05);
        tick(1);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h00);
        done_test("clear_on_match");
        wr(`ADDR_CMP_A, 8'h04);
        wr(`ADDR_CMP_B, 8'h02);
        wr(`ADDR_CTRL_A, 8'hE3);
        wr(`ADDR_CTRL_B, {4'h1, `CS_EXT_RISE});
        wr(`ADDR_COUNT, 8'h00);
        wr(`ADDR_FLAGS, 8'h07);
        tick(3);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h03);
        chk1(wb, 1'b0);
        tick(2);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h00);
        chk1(wb, 1'b1);
        chk1(wa, 1'b0);
        rd(`ADDR_FLAGS, d);
        chk8(d & 8'h01, 8'h01);
        wr(`ADDR_CMP_B, 8'h01);
        tick(2);
        chk1(wb, 1'b1);
        done_test("fast_pwm");
        wr(`ADDR_CTRL_A, 8'h00);
        wr(`ADDR_CTRL_B, {5'h00, `CS_EXT_RISE});
        wr(`ADDR_CMP_B, 8'h02);
        wr(`ADDR_CTRL_A, 8'hA1);
        wr(`ADDR_CTRL_B, {4'h1, `CS_EXT_RISE});
        wr(`ADDR_COUNT, 8'h00);
        wr(`ADDR_FLAGS, 8'h07);
        tick(3);
        chk1(wb, 1'b0);
        tick(1);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h04);
        tick(1);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h03);
        tick(2);
        chk1(wb, 1'b1);
        tick(2);
        rd(`ADDR_FLAGS, d);
        chk8(d & 8'h01, 8'h01);
        wr(`ADDR_CTRL_B, {5'h00, `CS_STOP});
        wr(`ADDR_COUNT, 8'h10);
        repeat (20) @(posedge clk_sys);
        rd(`ADDR_COUNT, d);
        chk8(d, 8'h10);
        done_test("phase_correct");
        report_and_stop();
    end
endmodule // timer_waveform_tb_top

// ===== dv/wave_pin_load.sv
// load on both waveform pins; a released pin shows the inverse of its last driven level
module wave_pin_load
(
    input  wire logic clk_sys,
    input  wire logic wave_a,
    input  wire logic oe_a_b,
    input  wire logic wave_b,
    input  wire logic oe_b_b,
    output logic      pin_a,
    output logic      pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_a_q = 1'b0;
    logic last_b_q = 1'b0;
    always @(posedge clk_sys)
    begin
        if (!oe_a_b) last_a_q <= wave_a;
        if (!oe_b_b) last_b_q <= wave_b;
    end
    // a floating pin must not look like the last value
    assign pin_a = oe_a_b ? ~last_a_q : wave_a;
    assign pin_b = oe_b_b ? ~last_b_q : wave_b;
endmodule // wave_pin_load

// ===== shared/timer_defines.vh
// register map, field positions and mode codes of the waveform timer
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
`define ADDR_CTRL_A      3'h0
`define ADDR_CTRL_B      3'h1
`define ADDR_COUNT       3'h2
`define ADDR_CMP_A       3'h3
`define ADDR_CMP_B       3'h4
`define ADDR_FLAGS       3'h5
`define CTRL_A_WMASK     8'hF3
`define CTRL_B_WMASK     8'h0F
`define FLAGS_WMASK      8'h07
`define BIT_WGM_HI       3
`define BIT_FLAG_OVF     0
`define BIT_FLAG_MA      1
`define BIT_FLAG_MB      2
`define VAL_BOTTOM       8'h00
`define VAL_MAX          8'hFF
`define MODE_NORMAL      3'h0
`define MODE_PC_FIX      3'h1
`define MODE_CTC         3'h2
`define MODE_FAST_FIX    3'h3
`define MODE_PC_VAR      3'h5
`define MODE_FAST_VAR    3'h7
`define COM_OFF          2'h0
`define COM_TOGGLE       2'h1
`define COM_CLEAR        2'h2
`define COM_SET          2'h3
`define CS_STOP          3'h0
`define CS_DIV1          3'h1
`define CS_DIV8          3'h2
`define CS_DIV64         3'h3
`define CS_DIV256        3'h4
`define CS_DIV1024       3'h5
`define CS_EXT_FALL      3'h6
`define CS_EXT_RISE      3'h7
`define PRESCALE_WIDTH   10
`endif
